// ---- dv/cgi_host_model.sv ----
// Serial bus controller model driving the bus clock and data lines
`timescale 1ns/1ps
`default_nettype none
module cgi_host_model (
	input  wire logic sys_clk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_low
);

	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : wait_clk

	// Data moves mid low phase, well clear of both clock edges
	task automatic bit_slot(input logic v, output logic s);
		wait_clk(3);
		sda_low = ~v;
		wait_clk(3);
		scl = 1'b1;
		wait_clk(2);
		s = sda_line;
		scl = 1'b0;
	endtask : bit_slot

	task automatic start_cond();
		wait_clk(4);
		sda_low = 1'b1;
		wait_clk(4);
		scl = 1'b0;
	endtask : start_cond

	task automatic restart_cond();
		wait_clk(3);
		sda_low = 1'b0;
		wait_clk(3);
		scl = 1'b1;
		start_cond();
	endtask : restart_cond

	task automatic stop_cond();
		wait_clk(3);
		sda_low = 1'b1;
		wait_clk(3);
		scl = 1'b1;
		wait_clk(4);
		sda_low = 1'b0;
		wait_clk(4);
	endtask : stop_cond

	// Address, index, count or data byte, MSB first
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(b[i], s);
		end
		bit_slot(1'b1, s);
		ack = ~s;
	endtask : send_byte

	// Acknowledge unless last, then not-acknowledge
	task automatic recv_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(1'b1, s);
			d[i] = s;
		end
		bit_slot(last, s);
	endtask : recv_byte

endmodule : cgi_host_model
`default_nettype wire

// ---- dv/cgi_i2c_target_test.sv ----
// Self-checking bench for the serial target port of the clock generator
`timescale 1ns/1ps
`default_nettype none
module cgi_i2c_target_test;

	logic       sys_clk;
	logic       sys_rst;
	logic       scl;
	logic       sda_low;
	logic       sda_o;
	logic       sda_oe;
	logic       fs_a;
	logic       fs_b;
	logic [2:0] cpu_en;
	logic       src_en;
	logic       src_fr;
	logic [1:0] fs_rb;
	wire logic  sda_line;
	int         miscompares;
	int         tests_run;

	// Open drain with pull-up
	assign sda_line = ~((sda_oe & ~sda_o) | sda_low);

	cgi_i2c_target i_cgi_i2c_target (
		.sys_clk                        (sys_clk),
		.sys_rst                        (sys_rst),
		.scl_i                          (scl),
		.sda_i                          (sda_line),
		.sda_o                          (sda_o),
		.sda_oe                         (sda_oe),
		.fs_a_i                         (fs_a),
		.fs_b_i                         (fs_b),
		.processor_pair_enable          (cpu_en),
		.serial_ref_pair_enable         (src_en),
		.serial_ref_pair_freerun_select (src_fr),
		.freq_select_readback           (fs_rb)
	);

	cgi_host_model i_cgi_host_model (
		.sys_clk  (sys_clk),
		.sda_line (sda_line),
		.scl      (scl),
		.sda_low  (sda_low)
	);

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic finish_test();
		$display("Counts: tests_run %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			miscompares++;
		end
	endtask : chk

	task automatic send(input logic [7:0] b, input logic exp_ack, input string nm);
		logic a;
		i_cgi_host_model.send_byte(b, a);
		chk(nm, {7'h00, exp_ack}, {7'h00, a});
	endtask : send

	task automatic recv(input logic last, input logic [7:0] exp, input string nm);
		logic [7:0] d;
		i_cgi_host_model.recv_byte(last, d);
		chk(nm, exp, d);
	endtask : recv

	task automatic chk_outs(input logic [7:0] exp);
		i_cgi_host_model.wait_clk(4);
		chk("outputs", exp, {src_fr, src_en, 3'h0, cpu_en});
	endtask : chk_outs

	task automatic wr_block(input logic [7:0] n, input logic [7:0] x, input logic [7:0] d0,
			input logic [7:0] d1);
		i_cgi_host_model.start_cond();
		send({cgi_pkg::DEV_ADDR, 1'b0}, 1'b1, "write address ack");
		send(n, 1'b1, "index ack");
		send(x, 1'b1, "count ack");
		if (x > 8'h00)
			send(d0, 1'b1, "data0 ack");
		if (x > 8'h01)
			send(d1, 1'b1, "data1 ack");
		i_cgi_host_model.stop_cond();
	endtask : wr_block

	task automatic rd_open(input logic [7:0] n);
		i_cgi_host_model.start_cond();
		send({cgi_pkg::DEV_ADDR, 1'b0}, 1'b1, "write address ack");
		send(n, 1'b1, "index ack");
		i_cgi_host_model.restart_cond();
		send({cgi_pkg::DEV_ADDR, 1'b1}, 1'b1, "read address ack");
	endtask : rd_open

	task automatic t_reset();
		chk_outs(8'h47);
		chk("freq readback", 8'h02, {6'h00, fs_rb});
	endtask : t_reset

	// Index 0 write ignored, index advances into the control byte
	task automatic t_write();
		wr_block(8'h00, 8'h02, 8'h00, 8'h82);
		chk_outs(8'h82);
		chk("freq readback", 8'h02, {6'h00, fs_rb});
	endtask : t_write

	task automatic t_read();
		wr_block(8'h08, 8'h01, 8'h03, 8'h00);
		rd_open(8'h00);
		recv(1'b0, 8'h03, "count byte");
		recv(1'b0, 8'h02, "index0");
		recv(1'b0, 8'h82, "index1");
		recv(1'b1, 8'h00, "index2");
		i_cgi_host_model.wait_clk(4);
		chk("sda_oe after nack", 8'h00, {7'h00, sda_oe});
		i_cgi_host_model.stop_cond();
	endtask : t_read

	task automatic t_reserved();
		wr_block(8'h01, 8'h01, 8'hff, 8'h00);
		chk_outs(8'hc7);
		rd_open(8'h01);
		recv(1'b0, 8'h03, "count byte");
		recv(1'b1, 8'hc7, "index1 reserved");
		i_cgi_host_model.stop_cond();
	endtask : t_reserved

	task automatic t_refuse();
		i_cgi_host_model.start_cond();
		send(8'ha4, 1'b0, "foreign address nack");
		i_cgi_host_model.stop_cond();
		i_cgi_host_model.start_cond();
		send({cgi_pkg::DEV_ADDR, 1'b0}, 1'b1, "write address ack");
		send(8'h01, 1'b1, "index ack");
		send(8'h01, 1'b1, "count ack");
		send(8'h05, 1'b1, "data ack");
		send(8'hff, 1'b0, "excess data nack");
		i_cgi_host_model.stop_cond();
		chk_outs(8'h05);
	endtask : t_refuse

	initial begin
		miscompares = 0;
		tests_run = 0;
		sys_rst = 1'b1;
		fs_a = 1'b0;
		fs_b = 1'b1;
		repeat (16) @(negedge sys_clk);
		sys_rst = 1'b0;
		repeat (8) @(negedge sys_clk);
		t_reset();
		t_write();
		t_read();
		t_reserved();
		t_refuse();
		finish_test();
	end

	initial begin
		repeat (40000) @(posedge sys_clk);
		miscompares++;
		finish_test();
	end

endmodule : cgi_i2c_target_test
`default_nettype wire

// ---- logic/cgi_i2c_target.sv ----
// Serial-bus target with indexed block access to the output control bytes
// Behaviour
// - Device acknowledges its address, the starting index and the byte count.
// - X data bytes land in registers N to N+X-1, index advancing each byte.
// - Every data byte within the count is acknowledged on its own; a byte beyond it is not.
// - Read address D3 follows the repeated START and the device acknowledges.
// - First byte sent on a read is the byte count.
// - After the count, register contents from index N at consecutive indexes.
// - Returned byte count comes from register index 8.
// - On a not-acknowledge the device releases the data line and stops sending.
// - Index 1 holds SRC free-run select, SRC enable and CPU pair enables.
`timescale 1ns/1ps
`default_nettype none
module cgi_i2c_target (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe,
	input  wire logic       fs_a_i,
	input  wire logic       fs_b_i,
	output logic [2:0]      processor_pair_enable,
	output logic            serial_ref_pair_enable,
	output logic            serial_ref_pair_freerun_select,
	output logic [1:0]      freq_select_readback
);
	typedef struct packed {
		cgi_pkg::cgi_state_t st;
		cgi_pkg::cgi_role_t  role;
		logic [7:0]          sh;
		logic [2:0]          bits;
		logic [7:0]          idx;
		logic [7:0]          wcount;
		logic                is_read;
		logic                oe;
		logic [7:0]          ctrl;
		logic [7:0]          byte_count;
		logic [1:0]          fs_s1;
		logic [1:0]          fs_s2;
		logic [1:0]          fs;
		logic [1:0]          fs_done;
		logic                scl_s1;
		logic                scl_s2;
		logic                scl_d;
		logic                sda_s1;
		logic                sda_s2;
		logic                sda_d;
	} cgi_state_reg_t;

	localparam cgi_state_reg_t RESET_VAL = '{
		st: cgi_pkg::ST_IDLE, role: cgi_pkg::ROLE_ADDR, sh: 8'h00, bits: 3'h0,
		idx: 8'h00, wcount: 8'h00, is_read: 1'b0, oe: 1'b0,
		ctrl: cgi_pkg::CTRL_RESET, byte_count: cgi_pkg::BYTE_COUNT_RESET,
		fs_s1: 2'h0, fs_s2: 2'h0, fs: 2'h0, fs_done: 2'h0,
		scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
		sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1};

	cgi_state_reg_t s_r;
	cgi_state_reg_t s_nxt;

	logic        scl_rise;
	logic        scl_fall;
	logic        start_det;
	logic        stop_det;
	logic [7:0]  rx_byte;
	logic        push;
	logic        buf_in_ready;
	logic        buf_out_valid;
	logic        buf_out_ready;
	logic [15:0] buf_out_data;
	logic        load_now;
	logic        addr_hit;

	function automatic logic [7:0] reg_read(input logic [7:0] idx, input logic [7:0] ctrl,
			input logic [7:0] cnt, input logic [1:0] fs);
		logic [7:0] v;
		v = cgi_pkg::RESERVED_READ;
		unique case (idx)
			cgi_pkg::IDX_FREQ_READ:   v = {cgi_pkg::RESERVED_READ[7:2], fs};
			cgi_pkg::IDX_OUTPUT_CTRL: v = ctrl;
			cgi_pkg::IDX_BYTE_COUNT:  v = cnt;
			default:                  v = cgi_pkg::RESERVED_READ;
		endcase
		return v;
	endfunction : reg_read

	assign scl_rise  = s_r.scl_s2 & ~s_r.scl_d;
	assign scl_fall  = ~s_r.scl_s2 & s_r.scl_d;
	assign start_det = s_r.scl_s2 & s_r.scl_d & s_r.sda_d & ~s_r.sda_s2;
	assign stop_det  = s_r.scl_s2 & s_r.scl_d & ~s_r.sda_d & s_r.sda_s2;
	assign rx_byte   = s_r.sh;
	assign addr_hit  = (s_r.sh[7:1] == cgi_pkg::DEV_ADDR);
	assign push      = (s_r.st == cgi_pkg::ST_ACK_WAIT) & scl_fall & (s_r.role == cgi_pkg::ROLE_DATA)
		& (s_r.wcount != 8'h00) & buf_in_ready;
	assign load_now  = scl_fall & (((s_r.st == cgi_pkg::ST_ACK) & s_r.is_read)
		| (s_r.st == cgi_pkg::ST_TX_NEXT));
	// Register bank is busy fetching a read byte, so the buffer waits
	assign buf_out_ready = ~load_now;

	cgi_pair_buf #(
		.WIDTH (cgi_pkg::BUF_WIDTH),
		.DEPTH (cgi_pkg::BUF_DEPTH)
	) u_buf (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.in_valid  (push),
		.in_ready  (buf_in_ready),
		.in_data   ({s_r.idx, rx_byte}),
		.out_valid (buf_out_valid),
		.out_ready (buf_out_ready),
		.out_data  (buf_out_data)
	);

	always_comb begin
		logic [7:0] nb;
		nb = 8'h00;
		s_nxt = s_r;
		s_nxt.scl_s1 = scl_i;
		s_nxt.scl_s2 = s_r.scl_s1;
		s_nxt.scl_d  = s_r.scl_s2;
		s_nxt.sda_s1 = sda_i;
		s_nxt.sda_s2 = s_r.sda_s1;
		s_nxt.sda_d  = s_r.sda_s2;
		s_nxt.fs_s1  = {fs_b_i, fs_a_i};
		s_nxt.fs_s2  = s_r.fs_s1;
		if (s_r.fs_done != 2'h3) begin
			s_nxt.fs      = s_r.fs_s2;
			s_nxt.fs_done = s_r.fs_done + 2'h1;
		end
		if (buf_out_valid && buf_out_ready) begin
			unique case (buf_out_data[15:8])
				cgi_pkg::IDX_OUTPUT_CTRL:
					s_nxt.ctrl = buf_out_data[7:0] & cgi_pkg::CTRL_RW_MASK;
				cgi_pkg::IDX_BYTE_COUNT:
					s_nxt.byte_count = buf_out_data[7:0];
				default: ;
			endcase
		end
		if (load_now) begin
			if (s_r.st == cgi_pkg::ST_ACK) begin
				nb = s_r.byte_count;
			end else begin
				nb        = reg_read(s_r.idx, s_r.ctrl, s_r.byte_count, s_r.fs);
				s_nxt.idx = s_r.idx + 8'h01;
			end
		end
		if (start_det) begin
			s_nxt.st   = cgi_pkg::ST_RX;
			s_nxt.role = cgi_pkg::ROLE_ADDR;
			s_nxt.bits = 3'h0;
			s_nxt.oe   = 1'b0;
		end else if (stop_det) begin
			s_nxt.st = cgi_pkg::ST_IDLE;
			s_nxt.oe = 1'b0;
		end else begin
			unique case (s_r.st)
				cgi_pkg::ST_IDLE: ;
				cgi_pkg::ST_RX: if (scl_rise) begin
					s_nxt.sh   = {s_r.sh[6:0], s_r.sda_s2};
					s_nxt.bits = s_r.bits + 3'h1;
					if (s_r.bits == 3'h7)
						s_nxt.st = cgi_pkg::ST_ACK_WAIT;
				end
				cgi_pkg::ST_ACK_WAIT: if (scl_fall) begin
					s_nxt.st = cgi_pkg::ST_ACK;
					s_nxt.oe = 1'b1;
					unique case (s_r.role)
						cgi_pkg::ROLE_ADDR: begin
							s_nxt.is_read = rx_byte[0];
							if (!addr_hit) begin
								s_nxt.st = cgi_pkg::ST_IDLE;
								s_nxt.oe = 1'b0;
							end
						end
						cgi_pkg::ROLE_INDEX: s_nxt.idx = rx_byte;
						cgi_pkg::ROLE_COUNT: s_nxt.wcount = rx_byte;
						cgi_pkg::ROLE_DATA: begin
							if (push) begin
								s_nxt.idx    = s_r.idx + 8'h01;
								s_nxt.wcount = s_r.wcount - 8'h01;
							end else begin
								s_nxt.st = cgi_pkg::ST_IDLE;
								s_nxt.oe = 1'b0;
							end
						end
					endcase
				end
				cgi_pkg::ST_ACK: if (scl_fall) begin
					s_nxt.bits = 3'h0;
					s_nxt.oe   = 1'b0;
					s_nxt.st   = cgi_pkg::ST_RX;
					unique case (s_r.role)
						cgi_pkg::ROLE_ADDR: begin
							s_nxt.role = cgi_pkg::ROLE_INDEX;
							if (s_r.is_read) begin
								s_nxt.st = cgi_pkg::ST_TX;
								s_nxt.sh = nb;
								s_nxt.oe = ~nb[7];
							end
						end
						cgi_pkg::ROLE_INDEX: s_nxt.role = cgi_pkg::ROLE_COUNT;
						default:             s_nxt.role = cgi_pkg::ROLE_DATA;
					endcase
				end
				cgi_pkg::ST_TX: begin
					if (scl_rise) begin
						s_nxt.bits = s_r.bits + 3'h1;
						if (s_r.bits == 3'h7)
							s_nxt.st = cgi_pkg::ST_TX_LAST;
					end else if (scl_fall) begin
						s_nxt.sh = {s_r.sh[6:0], 1'b0};
						s_nxt.oe = ~s_r.sh[6];
					end
				end
				cgi_pkg::ST_TX_LAST: if (scl_fall) begin
					s_nxt.oe = 1'b0;
					s_nxt.st = cgi_pkg::ST_TX_ACK;
				end
				cgi_pkg::ST_TX_ACK: if (scl_rise) begin
					// Not-acknowledge ends the read; line stays released
					s_nxt.st = s_r.sda_s2 ? cgi_pkg::ST_IDLE : cgi_pkg::ST_TX_NEXT;
				end
				cgi_pkg::ST_TX_NEXT: if (scl_fall) begin
					s_nxt.st   = cgi_pkg::ST_TX;
					s_nxt.bits = 3'h0;
					s_nxt.sh   = nb;
					s_nxt.oe   = ~nb[7];
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			s_r <= RESET_VAL;
		else
			s_r <= s_nxt;
	end

	assign sda_o                          = 1'b0;
	assign sda_oe                         = s_r.oe;
	assign processor_pair_enable          = s_r.ctrl[cgi_pkg::CPU_EN_MSB:0];
	assign serial_ref_pair_enable         = s_r.ctrl[cgi_pkg::SRC_EN_BIT];
	assign serial_ref_pair_freerun_select = s_r.ctrl[cgi_pkg::SRC_FREERUN_BIT];
	assign freq_select_readback           = s_r.fs;

	ack_slot_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(s_r.st == cgi_pkg::ST_ACK_WAIT && scl_fall && !start_det && !stop_det
		&& s_r.role != cgi_pkg::ROLE_DATA && (s_r.role != cgi_pkg::ROLE_ADDR || addr_hit))
		|=> sda_oe)
		else $error("Header byte not acknowledged");
	data_ack_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		push && !start_det && !stop_det |=> sda_oe && s_r.st == cgi_pkg::ST_ACK)
		else $error("Stored data byte not acknowledged");
	index_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		push && !start_det && !stop_det |=> s_r.idx == $past(s_r.idx) + 8'h01)
		else $error("Write index did not advance");
	count_limit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(s_r.st == cgi_pkg::ST_ACK_WAIT && scl_fall && s_r.role == cgi_pkg::ROLE_DATA
		&& s_r.wcount == 8'h00) |=> !sda_oe && s_r.st == cgi_pkg::ST_IDLE)
		else $error("Data byte stored beyond the byte count");
	count_first_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(s_r.st == cgi_pkg::ST_ACK && s_r.is_read && s_r.role == cgi_pkg::ROLE_ADDR
		&& scl_fall && !start_det && !stop_det) |=> s_r.sh == $past(s_r.byte_count))
		else $error("Read did not open with the byte count");
	read_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(s_r.st == cgi_pkg::ST_TX_NEXT && scl_fall && !start_det && !stop_det)
		|=> s_r.idx == $past(s_r.idx) + 8'h01 && s_r.st == cgi_pkg::ST_TX)
		else $error("Read index did not advance");
	nack_release_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(s_r.st == cgi_pkg::ST_TX_ACK && scl_rise && s_r.sda_s2 && !start_det && !stop_det)
		|=> !sda_oe [*3])
		else $error("Data line driven after not-acknowledge");
	reserved_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(s_r.ctrl & ~cgi_pkg::CTRL_RW_MASK) == 8'h00)
		else $error("Reserved control bits took a written value");
	fs_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_r.fs_done == 2'h3 |=> $stable(freq_select_readback))
		else $error("Latched frequency selects changed");
	ctrl_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(buf_out_valid && buf_out_ready && buf_out_data[15:8] == cgi_pkg::IDX_OUTPUT_CTRL)
		|=> processor_pair_enable == $past(buf_out_data[2:0])
		&& serial_ref_pair_enable == $past(buf_out_data[6]))
		else $error("Output control write not applied");
endmodule : cgi_i2c_target
`default_nettype wire

// ---- logic/cgi_pair_buf.sv ----
// Small valid/ready buffer between the byte receiver and the register bank
`timescale 1ns/1ps
`default_nettype none
module cgi_pair_buf #(
	parameter int WIDTH = cgi_pkg::BUF_WIDTH,
	parameter int DEPTH = cgi_pkg::BUF_DEPTH
) (
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_depth
		$error("cgi_pair_buf: DEPTH must be a power of two >= 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wptr;
		logic [AW-1:0]               rptr;
		logic [AW:0]                 cnt;
	} cgi_buf_t;

	cgi_buf_t s_r;
	cgi_buf_t s_nxt;
	logic     push;
	logic     pop;

	assign in_ready  = (s_r.cnt != (AW + 1)'(DEPTH));
	assign out_valid = (s_r.cnt != '0);
	assign out_data  = s_r.mem[s_r.rptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.mem[s_r.wptr] = in_data;
			s_nxt.wptr          = AW'(s_r.wptr + 1'b1);
		end
		if (pop)
			s_nxt.rptr = AW'(s_r.rptr + 1'b1);
		if (push && !pop)
			s_nxt.cnt = (AW + 1)'(s_r.cnt + 1'b1);
		else if (pop && !push)
			s_nxt.cnt = (AW + 1)'(s_r.cnt - 1'b1);
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
endmodule : cgi_pair_buf
`default_nettype wire

// ---- logic/cgi_pkg.sv ----
// Constants and types shared by the clock-generator serial target port
package cgi_pkg;

	localparam logic [6:0] DEV_ADDR         = 7'h69;
	localparam logic [7:0] IDX_FREQ_READ    = 8'h00;
	localparam logic [7:0] IDX_OUTPUT_CTRL  = 8'h01;
	localparam logic [7:0] IDX_BYTE_COUNT   = 8'h08;
	localparam int         FS_B_BIT         = 1;
	localparam int         FS_A_BIT         = 0;
	localparam int         SRC_FREERUN_BIT  = 7;
	localparam int         SRC_EN_BIT       = 6;
	localparam int         CPU_EN_MSB       = 2;
	localparam logic [7:0] CTRL_RW_MASK     = 8'hc7;
	localparam logic [7:0] CTRL_RESET       = 8'h47;
	localparam logic [7:0] BYTE_COUNT_RESET = 8'h02;
	localparam logic [7:0] RESERVED_READ    = 8'h00;
	localparam int         BUF_DEPTH        = 2;
	localparam int         BUF_WIDTH        = 16;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_RX,
		ST_ACK_WAIT,
		ST_ACK,
		ST_TX,
		ST_TX_LAST,
		ST_TX_ACK,
		ST_TX_NEXT
	} cgi_state_t;

	typedef enum logic [1:0] {
		ROLE_ADDR,
		ROLE_INDEX,
		ROLE_COUNT,
		ROLE_DATA
	} cgi_role_t;

endpackage : cgi_pkg
